/* File: logic/stp_prescaler.sv */
// shared prescaler, tick selection and general timer control for two timers
// How it works
// - one shared divider, per-timer source select
// - select 1 ticks every system clock
// - taps at divide 8, 64, 256, 1024
// - divider runs free of select settings
// - first divided tick within 1..N+1 cycles
// - divider reset affects both timers
// - pin sampled each cycle into edge detector
// - rising-edge registers, falling-edge input stage
// - select 7 rising, 6 falling pin edges
// - pin edge to update 2.5..3.5 cycles
// - pin ticks bypass the divider
// - hold mode keeps divider reset asserted
// - clearing hold clears divider reset bit
// - reset bit self-clears unless hold set
// - capture select picks input a or b
// - select 0 gives no ticks
`timescale 1ns/10ps
`default_nettype none
module stp_prescaler
    import stp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [STP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [STP_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [STP_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [STP_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic [STP_SEL_W-1:0] tick_source_select_0,
    input wire logic [STP_SEL_W-1:0] tick_source_select_1,
    input wire logic external_count_pin_0,
    input wire logic external_count_pin_1,
    input wire logic capture_input_a,
    input wire logic capture_input_b,
    output logic timer_tick_0,
    output logic timer_tick_1,
    output logic capture_trigger
);
    ////////////////////////////////////////////////////////////////////////
    // bus slave state
    logic aw_held_reg;
    logic [STP_ADDR_W-1:0] awaddr_reg;
    logic w_held_reg;
    logic [STP_DATA_W-1:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic gtc_write;
    logic [STP_DATA_W-1:0] rdata_next;
    logic [1:0] rresp_next;

    // control register fields
    logic sync_hold_mode_reg;
    logic capture_input_select_reg;
    logic divider_reset_bit_reg;
    logic [7:0] gtc_value;

    // divider and taps
    logic [STP_DIV_W-1:0] div_reg;
    logic [3:0] tap_hit;

    // pin synchronisers for the capture inputs
    logic cap_a_meta_reg;
    logic cap_a_sync_reg;
    logic cap_b_meta_reg;
    logic cap_b_sync_reg;

    logic [STP_SEL_W-1:0] sel_vec [STP_NUM_TIMERS];
    logic [STP_NUM_TIMERS-1:0] pin_vec;
    logic [STP_NUM_TIMERS-1:0] tick_next;

    ////////////////////////////////////////////////////////////////////////
    // write address and data taken in either order, response after both
    // ready lines stay low from a take until the response is accepted
    assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign gtc_write = do_write & (awaddr_reg == STP_GTC_OFS) & wstrb_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
            s_axi_awready <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end else if (!aw_held_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end else if (!w_held_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response, okay for the control and divider words, error for any other address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= STP_RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_reg == STP_GTC_OFS || awaddr_reg == STP_DIV_OFS) ?
                               STP_RESP_OKAY : STP_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data mux
    assign gtc_value = {sync_hold_mode_reg, capture_input_select_reg, 5'h00, divider_reset_bit_reg};

    // the word is latched at the address take, so it never moves under rvalid
    always_comb begin
        rdata_next = '0;
        rresp_next = STP_RESP_OKAY;
        case (s_axi_araddr)
            STP_GTC_OFS: rdata_next = {24'h00_0000, gtc_value};
            STP_DIV_OFS: rdata_next = {22'h0_0000, div_reg};
            default: rresp_next = STP_RESP_SLVERR;
        endcase
    end

    // read address and data channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= STP_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_next;
                s_axi_rresp <= rresp_next;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general timer control register
    // a write beats the hardware clear when both fall in one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_hold_mode_reg <= STP_GTC_RESET[STP_GTC_HOLD_BIT];
            capture_input_select_reg <= STP_GTC_RESET[STP_GTC_CAP_BIT];
            divider_reset_bit_reg <= STP_GTC_RESET[STP_GTC_RST_BIT];
        end else if (clk_en) begin
            if (gtc_write) begin
                sync_hold_mode_reg <= wdata_reg[STP_GTC_HOLD_BIT];
                capture_input_select_reg <= wdata_reg[STP_GTC_CAP_BIT];
                // a hold-clear write with the reset bit set pulses it for one cycle
                divider_reset_bit_reg <= wdata_reg[STP_GTC_RST_BIT];
            end else if (!sync_hold_mode_reg) begin
                divider_reset_bit_reg <= 1'b0;
            end
            // with hold set the written bit simply stays
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // free-running shared divider, only the reset bit touches it
    // no select is read here, so enabling a timer keeps the divider phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= STP_DIV_RESET;
        end else if (clk_en) begin
            if (divider_reset_bit_reg) begin
                div_reg <= STP_DIV_RESET;
            end else begin
                div_reg <= div_reg + 10'h001;
            end
        end
    end

    // one-cycle tap pulses when the low bits roll over
    assign tap_hit[0] = (div_reg & STP_TAP8_MASK) == STP_TAP8_MASK;
    assign tap_hit[1] = (div_reg & STP_TAP64_MASK) == STP_TAP64_MASK;
    assign tap_hit[2] = (div_reg & STP_TAP256_MASK) == STP_TAP256_MASK;
    assign tap_hit[3] = (div_reg & STP_TAP1024_MASK) == STP_TAP1024_MASK;

    ////////////////////////////////////////////////////////////////////////
    // per-timer tick selection over the shared taps
    assign sel_vec[0] = tick_source_select_0;
    assign sel_vec[1] = tick_source_select_1;
    assign pin_vec = {external_count_pin_1, external_count_pin_0};

    for (genvar t = 0; t < STP_NUM_TIMERS; t++) begin : g_timer
        stp_edge_if edge_bus ();
        // local select result, so each bit of tick_next has one driver
        logic tick_sel;

        stp_ext_edge u_edge (
            .aclk(aclk),
            .aresetn(aresetn),
            .clk_en(clk_en),
            .external_count_pin(pin_vec[t]),
            .edge_out(edge_bus)
        );

        // internal sources halt while the divider reset is held
        always_comb begin
            case (sel_vec[t])
                STP_SEL_OFF: tick_sel = 1'b0;
                STP_SEL_CLK: tick_sel = ~divider_reset_bit_reg;
                STP_SEL_DIV8: tick_sel = tap_hit[0] & ~divider_reset_bit_reg;
                STP_SEL_DIV64: tick_sel = tap_hit[1] & ~divider_reset_bit_reg;
                STP_SEL_DIV256: tick_sel = tap_hit[2] & ~divider_reset_bit_reg;
                STP_SEL_DIV1024: tick_sel = tap_hit[3] & ~divider_reset_bit_reg;
                STP_SEL_FALL: tick_sel = edge_bus.fall;
                STP_SEL_RISE: tick_sel = edge_bus.rise;
                default: tick_sel = 1'b0;
            endcase
        end

        // hand the selected source to the shared output stage
        assign tick_next[t] = tick_sel;
    end

    // registered tick outputs, one cycle per tick, held high under select 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_tick_0 <= 1'b0;
            timer_tick_1 <= 1'b0;
        end else if (clk_en) begin
            timer_tick_0 <= tick_next[0];
            timer_tick_1 <= tick_next[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture inputs: two-stage synchronisers then the select mux
    // the pins are asynchronous, so only the second stage feeds the mux
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_a_meta_reg <= 1'b0;
            cap_a_sync_reg <= 1'b0;
            cap_b_meta_reg <= 1'b0;
            cap_b_sync_reg <= 1'b0;
        end else if (clk_en) begin
            cap_a_meta_reg <= capture_input_a;
            cap_a_sync_reg <= cap_a_meta_reg;
            cap_b_meta_reg <= capture_input_b;
            cap_b_sync_reg <= cap_b_meta_reg;
        end
    end

    // timer 1 capture trigger source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_trigger <= 1'b0;
        end else if (clk_en) begin
            capture_trigger <= capture_input_select_reg ? cap_b_sync_reg : cap_a_sync_reg;
        end
    end
endmodule
`default_nettype wire

/* File: logic/stp_pkg.sv */
// constants for the shared timer prescaler block
package stp_pkg;
    // register bus geometry
    localparam int STP_ADDR_W = 4;
    localparam int STP_DATA_W = 32;
    localparam logic [STP_ADDR_W-1:0] STP_GTC_OFS = 4'h0;
    localparam logic [STP_ADDR_W-1:0] STP_DIV_OFS = 4'h4;
    localparam logic [1:0] STP_RESP_OKAY = 2'h0;
    localparam logic [1:0] STP_RESP_SLVERR = 2'h2;
    // general timer control field positions and reset value
    localparam int STP_GTC_RST_BIT = 0;
    localparam int STP_GTC_CAP_BIT = 6;
    localparam int STP_GTC_HOLD_BIT = 7;
    localparam logic [7:0] STP_GTC_RESET = 8'h00;
    // shared divider
    localparam int STP_DIV_W = 10;
    localparam logic [STP_DIV_W-1:0] STP_DIV_RESET = 10'h000;
    localparam logic [STP_DIV_W-1:0] STP_TAP8_MASK = 10'h007;
    localparam logic [STP_DIV_W-1:0] STP_TAP64_MASK = 10'h03f;
    localparam logic [STP_DIV_W-1:0] STP_TAP256_MASK = 10'h0ff;
    localparam logic [STP_DIV_W-1:0] STP_TAP1024_MASK = 10'h3ff;
    // tick source select codes
    localparam int STP_SEL_W = 3;
    localparam logic [2:0] STP_SEL_OFF = 3'h0;
    localparam logic [2:0] STP_SEL_CLK = 3'h1;
    localparam logic [2:0] STP_SEL_DIV8 = 3'h2;
    localparam logic [2:0] STP_SEL_DIV64 = 3'h3;
    localparam logic [2:0] STP_SEL_DIV256 = 3'h4;
    localparam logic [2:0] STP_SEL_DIV1024 = 3'h5;
    localparam logic [2:0] STP_SEL_FALL = 3'h6;
    localparam logic [2:0] STP_SEL_RISE = 3'h7;
    localparam int STP_NUM_TIMERS = 2;
endpackage

/* File: logic/stp_edge_if.sv */
// edge events from one count pin detector to the tick selector
`timescale 1ns/10ps
`default_nettype none
interface stp_edge_if;
    logic rise;
    logic fall;
    modport det (output rise, output fall);
    modport sel (input rise, input fall);
endinterface
`default_nettype wire

/* File: logic/stp_ext_edge.sv */
// count pin synchroniser and edge detector
`timescale 1ns/10ps
`default_nettype none
module stp_ext_edge (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic external_count_pin,
    stp_edge_if.det edge_out
);
    logic latch_reg;
    logic sync_reg;
    logic last_reg;

    // input stage, captures at the end of the high phase like a high-transparent latch
    always_ff @(negedge aclk) begin
        if (!aresetn) begin
            latch_reg <= 1'b0;
        end else if (clk_en) begin
            latch_reg <= external_count_pin;
        end
    end

    // rising-edge synchroniser and previous-sample store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else if (clk_en) begin
            sync_reg <= latch_reg;
            last_reg <= sync_reg;
        end
    end

    // one pulse per detected edge of the synchronised level
    assign edge_out.rise = sync_reg & ~last_reg;
    assign edge_out.fall = ~sync_reg & last_reg;
endmodule
`default_nettype wire

/* File: verif/stp_timer_model.sv */
// partner model: one timer counter advancing on each tick pulse
`timescale 1ns/10ps
`default_nettype none
module stp_timer_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    output logic [15:0] count
);
    // step once per tick pulse, stand still without one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 16'h0000;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: verif/stp_prescaler_assertions.sv */
// port checker for the shared timer prescaler
`timescale 1ns/10ps
`default_nettype none
module stp_prescaler_chk
    import stp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [STP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [STP_DATA_W-1:0] s_axi_rdata,
    input wire logic [STP_SEL_W-1:0] tick_source_select_0,
    input wire logic [STP_SEL_W-1:0] tick_source_select_1,
    input wire logic external_count_pin_0,
    input wire logic external_count_pin_1,
    input wire logic capture_input_a,
    input wire logic capture_input_b,
    input wire logic timer_tick_0,
    input wire logic timer_tick_1,
    input wire logic capture_trigger
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [STP_ADDR_W-1:0] ra_reg;
    // remember the address of the read under way
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ra_reg <= 4'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ra_reg <= s_axi_araddr;
        end
    end
    ////////////////////////////////////////////////////////////
    // pin quiet low, then a rise while falling edges are selected
    sequence s_quiet_rise;
        (!external_count_pin_1) [*6] ##1 (external_count_pin_1 && tick_source_select_1 == STP_SEL_FALL);
    endsequence
    property p_off;
        tick_source_select_0 == STP_SEL_OFF |=> !timer_tick_0;
    endproperty
    a_off: assert property (p_off) else $error("tick with source off");
    property p_same;
        (tick_source_select_0 == tick_source_select_1 && tick_source_select_0 inside {[1:5]})
            |=> timer_tick_0 == timer_tick_1;
    endproperty
    a_same: assert property (p_same) else $error("timers disagree on shared source");
    property p_gap;
        (timer_tick_0 && $past(tick_source_select_0) == STP_SEL_DIV8)
            |=> (!(timer_tick_0 && $past(tick_source_select_0) inside {[2:5]})) [*7];
    endproperty
    a_gap: assert property (p_gap) else $error("divided ticks closer than 8");
    property p_rise;
        ($rose(external_count_pin_0) && tick_source_select_0 == STP_SEL_RISE) |-> ##[1:4] timer_tick_0;
    endproperty
    a_rise: assert property (p_rise) else $error("rising pin edge lost");
    property p_fall;
        ($fell(external_count_pin_1) && tick_source_select_1 == STP_SEL_FALL) |-> ##[1:4] timer_tick_1;
    endproperty
    a_fall: assert property (p_fall) else $error("falling pin edge lost");
    property p_no_rise;
        s_quiet_rise |=> (!timer_tick_1) [*4];
    endproperty
    a_no_rise: assert property (p_no_rise) else $error("tick on wrong pin edge");
    property p_capt;
        (capture_input_a && capture_input_b) [*5] |-> capture_trigger;
    endproperty
    a_capt: assert property (p_capt) else $error("capture level not passed");
    property p_rzero;
        (s_axi_rvalid && ra_reg == STP_GTC_OFS) |-> (s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rdata[5:1] == 5'h00);
    endproperty
    a_rzero: assert property (p_rzero) else $error("unused control bits read nonzero");
endmodule
bind stp_prescaler stp_prescaler_chk chk_u (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rdata, .tick_source_select_0, .tick_source_select_1, .external_count_pin_0,
    .external_count_pin_1, .capture_input_a, .capture_input_b, .timer_tick_0, .timer_tick_1, .capture_trigger);
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the shared timer prescaler
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import stp_pkg::*;
    logic aclk, aresetn, awv, awrd, wv, wrd, bv, br, arv, ard, rv, rr, pin0, pin1, cap_a, cap_b, tk0, tk1, trig;
    logic [3:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0] bresp, rresp;
    logic [2:0] sel0, sel1;
    logic [15:0] cnt0, cnt1;
    int fail_count, checks_done;
    stp_prescaler dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awvalid(awv), .s_axi_awready(awrd),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(ard),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .tick_source_select_0(sel0), .tick_source_select_1(sel1), .external_count_pin_0(pin0),
        .external_count_pin_1(pin1), .capture_input_a(cap_a), .capture_input_b(cap_b), .timer_tick_0(tk0),
        .timer_tick_1(tk1), .capture_trigger(trig));
    stp_timer_model tm0 (.aclk(aclk), .aresetn(aresetn), .tick(tk0), .count(cnt0));
    stp_timer_model tm1 (.aclk(aclk), .aresetn(aresetn), .tick(tk1), .count(cnt1));
    ////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one write, address and data offered together
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        br <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | (awrd & awv);
            w = w | (wrd & wv);
            awv <= !aw;
            wv <= !w;
        end
        do @(posedge aclk); while (!bv);
        br <= 1'b0;
        chk("write resp", e, bresp);
    endtask
    // one read; data judged only when an okay response is expected
    task automatic bus_rd(input logic [3:0] a, input logic [1:0] e, input logic [31:0] d);
        @(posedge aclk);
        arv <= 1'b1;
        ara <= a;
        rr <= 1'b1;
        do @(posedge aclk); while (!ard);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        rr <= 1'b0;
        chk("read resp", e, rresp);
        if (e === STP_RESP_OKAY) chk("read data", d, rd);
    endtask
    // cycles until timer 0 sees a tick
    task automatic tick_wait(output int c);
        c = 0;
        do begin
            @(posedge aclk);
            c++;
        end while (!tk0 && c < 3000);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        bus_rd(STP_GTC_OFS, STP_RESP_OKAY, 32'h0000_0000);
        bus_rd(4'h8, STP_RESP_SLVERR, 32'h0000_0000);
        bus_wr(4'h8, 32'h0000_0001, STP_RESP_SLVERR);
        bus_wr(STP_DIV_OFS, 32'h0000_0001, STP_RESP_OKAY);
        bus_wr(STP_GTC_OFS, 32'h0000_007e, STP_RESP_OKAY);
        bus_rd(STP_GTC_OFS, STP_RESP_OKAY, 32'h0000_0040);
        bus_wr(STP_GTC_OFS, 32'h0000_0000, STP_RESP_OKAY);
    endtask
    task automatic t_hold();
        logic [15:0] c;
        sel0 <= STP_SEL_CLK;
        sel1 <= STP_SEL_CLK;
        bus_wr(STP_GTC_OFS, 32'h0000_0081, STP_RESP_OKAY);
        bus_rd(STP_GTC_OFS, STP_RESP_OKAY, 32'h0000_0081);
        bus_rd(STP_DIV_OFS, STP_RESP_OKAY, 32'h0000_0000);
        c = cnt0;
        repeat (20) @(posedge aclk);
        chk("held count", c, cnt0);
        bus_wr(STP_GTC_OFS, 32'h0000_0001, STP_RESP_OKAY);
        bus_rd(STP_GTC_OFS, STP_RESP_OKAY, 32'h0000_0000);
        c = cnt0;
        repeat (20) @(posedge aclk);
        chk("clock count", c + 16'h0014, cnt0);
    endtask
    task automatic t_taps();
        int nt[4] = '{8, 64, 256, 1024};
        int c;
        logic [15:0] c1;
        // both timers stop first; two ticks launched under select 1 still land
        sel0 <= STP_SEL_OFF;
        sel1 <= STP_SEL_OFF;
        c1 = cnt1 + 16'h0002;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            sel0 <= STP_SEL_DIV8 + 3'(i);
            tick_wait(c);
            chk("first tick in range", 1, c >= 1 && c <= nt[i] + 1);
            tick_wait(c);
            chk("tap period", nt[i], c);
        end
        chk("idle timer count", c1, cnt1);
        sel0 <= STP_SEL_DIV64;
        sel1 <= STP_SEL_DIV64;
        tick_wait(c);
        repeat (20) @(posedge aclk);
        bus_wr(STP_GTC_OFS, 32'h0000_0001, STP_RESP_OKAY);
        tick_wait(c);
        chk("restart gap in range", 1, c >= 62 && c <= 67);
        chk("other timer restarted", 1, tk1);
        bus_rd(STP_GTC_OFS, STP_RESP_OKAY, 32'h0000_0000);
    endtask
    task automatic t_pins();
        logic [15:0] c0, c1;
        sel0 <= STP_SEL_RISE;
        sel1 <= STP_SEL_FALL;
        bus_wr(STP_GTC_OFS, 32'h0000_0081, STP_RESP_OKAY);
        c0 = cnt0;
        c1 = cnt1;
        // pins held 10 cycles per phase, selects changed only while quiet
        repeat (8) begin
            repeat (10) @(posedge aclk);
            pin0 <= !pin0;
            pin1 <= !pin1;
        end
        repeat (10) @(posedge aclk);
        chk("rising edge ticks", c0 + 16'h0004, cnt0);
        chk("falling edge ticks", c1 + 16'h0004, cnt1);
        sel0 <= STP_SEL_OFF;
        sel1 <= STP_SEL_OFF;
        bus_wr(STP_GTC_OFS, 32'h0000_0040, STP_RESP_OKAY);
        cap_b <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("capture from b", 1, trig);
        bus_wr(STP_GTC_OFS, 32'h0000_0000, STP_RESP_OKAY);
        repeat (6) @(posedge aclk);
        chk("capture from a", 0, trig);
        cap_a <= 1'b1;
        repeat (6) @(posedge aclk);
        chk("capture from a high", 1, trig);
    endtask
    task automatic wrap_up();
        $display("fail_count %0d checks_done %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // clock at 5 ns
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // cut a hang short
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        {aresetn, awv, wv, br, arv, rr, pin0, pin1, cap_a, cap_b} = '0;
        {awa, ara, wd, sel0, sel1} = '0;
        fail_count = 0;
        checks_done = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_hold();
        t_taps();
        t_pins();
        wrap_up();
    end
endmodule
`default_nettype wire
